// File: rtl/fapec_defs.vh
// Timing and command constants for the flash program/erase host controller
`ifndef FAPEC_DEFS_VH
`define FAPEC_DEFS_VH
`define FAPEC_CLK_MHZ           40
// Operation kinds on op_sel_in
`define FAPEC_OP_PROGRAM        3'h0
`define FAPEC_OP_CHIP_ERASE     3'h1
`define FAPEC_OP_SECTOR_ERASE   3'h2
`define FAPEC_OP_PROTECT        3'h3
`define FAPEC_OP_UNPROTECT      3'h4
// Times in their own units
`define FAPEC_PROTECT_PULSE_US  10
`define FAPEC_UNPROTECT_PULSE_MS 12
`define FAPEC_PROTECT_OE_SETUP_US 4
`define FAPEC_SECTOR_LOAD_US    100
`define FAPEC_PROGRAM_MAX_US    210
`define FAPEC_CHIP_ERASE_MAX_S  32
`define FAPEC_SECTOR_ERASE_MAX_10THS 104
// Cycle counts (least times round up, figures are exact at 40 MHz)
`define FAPEC_PROTECT_PULSE_CYC   (`FAPEC_PROTECT_PULSE_US * `FAPEC_CLK_MHZ)
`define FAPEC_UNPROTECT_PULSE_CYC (`FAPEC_UNPROTECT_PULSE_MS * 1000 * `FAPEC_CLK_MHZ)
`define FAPEC_PROTECT_OE_SETUP_CYC (`FAPEC_PROTECT_OE_SETUP_US * `FAPEC_CLK_MHZ)
`define FAPEC_SECTOR_LOAD_CYC     (`FAPEC_SECTOR_LOAD_US * `FAPEC_CLK_MHZ)
`define FAPEC_PROGRAM_MAX_CYC     (`FAPEC_PROGRAM_MAX_US * `FAPEC_CLK_MHZ)
`define FAPEC_CHIP_ERASE_MAX_CYC  (`FAPEC_CHIP_ERASE_MAX_S * 1000000 * `FAPEC_CLK_MHZ)
`define FAPEC_SECTOR_ERASE_MAX_CYC (`FAPEC_SECTOR_ERASE_MAX_10THS * 100000 * `FAPEC_CLK_MHZ)
// Bus cycle phase lengths in clocks (25 ns each)
`define FAPEC_PHASE_CYC         3
`define FAPEC_TIMER_W           32
`define FAPEC_POLL_BIT          7
`define FAPEC_TOGGLE_BIT        6
`endif

// File: rtl/fapec_timer.v
// Loadable down-counter used for pulse widths and time limits
`timescale 1ns/1ps
`default_nettype none
module fapec_timer #(
  parameter W = 32
) (
  input  wire         sys_clk_in,
  input  wire         reset_n_in,
  input  wire         load_in,
  input  wire [W-1:0] count_in,
  output wire         done_out
);
  reg [W-1:0] cnt_q;
  always @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cnt_q <= {W{1'b0}};
    end else if (load_in) begin
      cnt_q <= count_in;
    end else if (cnt_q != {W{1'b0}}) begin
      cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
    end
  end
  assign done_out = (cnt_q == {W{1'b0}});
endmodule // fapec_timer
`default_nettype wire

// File: rtl/fapec_host.v
// Host controller that drives a byte-wide flash through its strobes and polls completion
`timescale 1ns/1ps
`default_nettype none
`include "fapec_defs.vh"
// Functional notes
// [R1] The flash verifies and repeats programming itself, so one program op ends on poll success.
// [R2] During programming the poll bit reads inverted data until done, then the true bit.
// [R3] Chip erase runs fully inside the flash and needs no verify from this controller.
// [R4] During erase the poll bit reads 0 and turns to 1 when erasure is finished.
// [R5] Bit six toggles on successive reads while an operation is busy.
// [R6] Sector erase selects the sector with the six uppermost address bits.
// [R7] Further sector addresses may be loaded inside the sector load window after the last.
// [R8] A chip erase completes within 32 seconds.
// [R9] A sector erase completes within 10.4 seconds.
// [R10] A byte program completes within 210 microseconds.
// [R11] The protect write pulse stays low for at least 10 microseconds.
// [R12] The unprotect write pulse stays low for at least 12 milliseconds.
// [R13] Output enable is set up at least 4 microseconds before the write strobe falls.
// [R14] A write happens only with chip select and write low and output enable high.
// [R15] The flash starts in read mode and only a full command sequence alters it.
// [R16] While busy the flash returns status bits on reads instead of array data.
module fapec_host #(
  parameter ADDR_W       = 19,
  parameter PROG_MAX     = `FAPEC_PROGRAM_MAX_CYC,
  parameter CHIP_MAX     = `FAPEC_CHIP_ERASE_MAX_CYC,
  parameter SECT_MAX     = `FAPEC_SECTOR_ERASE_MAX_CYC,
  parameter UNPROT_PULSE = `FAPEC_UNPROTECT_PULSE_CYC,
  parameter LOAD_WINDOW  = `FAPEC_SECTOR_LOAD_CYC
) (
  input  wire              sys_clk_in,
  input  wire              reset_n_in,
  input  wire              start_in,
  input  wire [2:0]        op_sel_in,
  input  wire [ADDR_W-1:0] addr_in,
  input  wire [7:0]        data_in,
  output wire              ready_out,
  output reg               done_out,
  output reg               timeout_out,
  output reg  [ADDR_W-1:0] flash_addr_out,
  output reg  [7:0]        flash_dq_out,
  output reg               flash_dq_oe_out,
  input  wire [7:0]        flash_dq_in,
  output reg               flash_ce_n_out,
  output reg               flash_oe_n_out,
  output reg               flash_we_n_out
);
  localparam TW = `FAPEC_TIMER_W;
  localparam [8:0] S_IDLE  = 9'h001;
  localparam [8:0] S_CMD   = 9'h002;
  localparam [8:0] S_WLOW  = 9'h004;
  localparam [8:0] S_WHIGH = 9'h008;
  localparam [8:0] S_POLL  = 9'h010;
  localparam [8:0] S_PSAMP = 9'h020;
  localparam [8:0] S_OESET = 9'h040;
  localparam [8:0] S_PPULSE= 9'h080;
  localparam [8:0] S_DONE  = 9'h100;
  localparam [3:0] PH = `FAPEC_PHASE_CYC;
  localparam [ADDR_W-1:0] CMD_A1   = {{(ADDR_W-12){1'b0}}, 12'h555};
  localparam [ADDR_W-1:0] CMD_A2   = {{(ADDR_W-12){1'b0}}, 12'h2AA};
  // Limits fixed to the timer width here, so no load truncates silently
  localparam [TW-1:0]     T_PROG   = PROG_MAX;
  localparam [TW-1:0]     T_CHIP   = CHIP_MAX;
  localparam [TW-1:0]     T_SECT   = SECT_MAX + LOAD_WINDOW;
  localparam [TW-1:0]     T_OESET  = `FAPEC_PROTECT_OE_SETUP_CYC;
  localparam [TW-1:0]     T_PROT   = `FAPEC_PROTECT_PULSE_CYC;
  localparam [TW-1:0]     T_UNPROT = UNPROT_PULSE;

  reg [8:0]        st_q;
  reg [2:0]        op_q;
  reg [ADDR_W-1:0] addr_q;
  reg [7:0]        data_q;
  reg [2:0]        idx_q;
  reg [3:0]        ph_q;
  reg              tmr_load;
  reg [TW-1:0]     tmr_val;
  wire             tmr_done;
  reg [7:0]        dq_s1_q;
  reg [7:0]        dq_s2_q;
  reg              tog_q;
  reg              first_q;

  fapec_timer #(.W(TW)) u_timer (
    .sys_clk_in (sys_clk_in),
    .reset_n_in (reset_n_in),
    .load_in    (tmr_load),
    .count_in   (tmr_val),
    .done_out   (tmr_done)
  );

  assign ready_out = (st_q == S_IDLE);

  // Data bus from the pins is asynchronous to this clock
  always @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      dq_s1_q <= 8'h00;
      dq_s2_q <= 8'h00;
    end else begin
      dq_s1_q <= flash_dq_in;
      dq_s2_q <= dq_s1_q;
    end
  end

  // Number of command writes per operation; last write carries the operand
  function [2:0] n_writes;
    input [2:0] op;
    begin
      case (op)
        `FAPEC_OP_PROGRAM:      n_writes = 3'd4;
        `FAPEC_OP_CHIP_ERASE:   n_writes = 3'd6;
        `FAPEC_OP_SECTOR_ERASE: n_writes = 3'd6;
        default:                n_writes = 3'd0;
      endcase
    end
  endfunction

  // Unlock-style command sequence; codes are parameters of the device command set
  function [ADDR_W+7:0] cmd_word;
    input [2:0]        op;
    input [2:0]        i;
    input [ADDR_W-1:0] a;
    input [7:0]        d;
    begin
      case (i)
        3'd0:    cmd_word = {CMD_A1, 8'hAA};
        3'd1:    cmd_word = {CMD_A2, 8'h55};
        3'd2:    cmd_word = {CMD_A1, (op == `FAPEC_OP_PROGRAM) ? 8'hA0 : 8'h80};
        3'd3:    cmd_word = (op == `FAPEC_OP_PROGRAM) ? {a, d} : {CMD_A1, 8'hAA};
        3'd4:    cmd_word = {CMD_A2, 8'h55};
        default: cmd_word = (op == `FAPEC_OP_SECTOR_ERASE) ? {a, 8'h30} : {CMD_A1, 8'h10};
      endcase
    end
  endfunction

  wire [ADDR_W+7:0] cur_cmd = cmd_word(op_q, idx_q, addr_q, data_q);
  // Program polls for true data, erases poll for 1
  wire poll_ok = (op_q == `FAPEC_OP_PROGRAM) ?
                 (dq_s2_q[`FAPEC_POLL_BIT] == data_q[`FAPEC_POLL_BIT]) : // R2
                 dq_s2_q[`FAPEC_POLL_BIT];                               // R4

  always @* begin
    tmr_load = 1'b0;
    tmr_val  = {TW{1'b0}};
    if (st_q == S_WHIGH && ph_q == PH && idx_q == n_writes(op_q) - 3'd1) begin
      tmr_load = 1'b1;
      case (op_q)
        `FAPEC_OP_PROGRAM:    tmr_val = T_PROG; // R10
        `FAPEC_OP_CHIP_ERASE: tmr_val = T_CHIP; // R8
        default:              tmr_val = T_SECT; // R9 R7
      endcase
    end else if (st_q == S_IDLE && start_in &&
                 (op_sel_in == `FAPEC_OP_PROTECT || op_sel_in == `FAPEC_OP_UNPROTECT)) begin
      tmr_load = 1'b1;
      tmr_val  = T_OESET; // R13
    end else if (st_q == S_OESET && tmr_done) begin
      tmr_load = 1'b1;
      tmr_val  = (op_q == `FAPEC_OP_PROTECT) ? T_PROT    // R11
                                            : T_UNPROT; // R12
    end
  end

  always @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st_q            <= S_IDLE;
      op_q            <= 3'd0;
      addr_q          <= {ADDR_W{1'b0}};
      data_q          <= 8'h00;
      idx_q           <= 3'd0;
      ph_q            <= 4'd0;
      tog_q           <= 1'b0;
      first_q         <= 1'b0;
      done_out        <= 1'b0;
      timeout_out     <= 1'b0;
      flash_addr_out  <= {ADDR_W{1'b0}};
      flash_dq_out    <= 8'h00;
      flash_dq_oe_out <= 1'b0;
      flash_ce_n_out  <= 1'b1;
      flash_oe_n_out  <= 1'b1;
      flash_we_n_out  <= 1'b1;
    end else begin
      done_out <= 1'b0;
      case (st_q)
        S_IDLE: begin
          // Flash sits in read mode here; only protect and unprotect pulse the write strobe without a full sequence
          flash_ce_n_out  <= 1'b1;
          flash_oe_n_out  <= 1'b1;
          flash_we_n_out  <= 1'b1;
          flash_dq_oe_out <= 1'b0;
          if (start_in) begin
            op_q        <= op_sel_in;
            addr_q      <= addr_in;
            data_q      <= data_in;
            idx_q       <= 3'd0;
            ph_q        <= 4'd0;
            timeout_out <= 1'b0;
            if (op_sel_in == `FAPEC_OP_PROTECT || op_sel_in == `FAPEC_OP_UNPROTECT) begin
              flash_ce_n_out <= 1'b0;
              flash_oe_n_out <= 1'b1;
              st_q           <= S_OESET; // R13
            end else if (op_sel_in <= `FAPEC_OP_SECTOR_ERASE) begin
              st_q <= S_CMD; // R15
            end
          end
        end
        S_CMD: begin
          flash_addr_out  <= cur_cmd[ADDR_W+7:8];
          flash_dq_out    <= cur_cmd[7:0];
          flash_dq_oe_out <= 1'b1;
          flash_oe_n_out  <= 1'b1; // R14
          flash_ce_n_out  <= 1'b0; // R14
          ph_q            <= 4'd0;
          st_q            <= S_WLOW;
        end
        S_WLOW: begin
          flash_we_n_out <= 1'b0; // R14
          ph_q           <= ph_q + 4'd1;
          if (ph_q == PH) begin
            flash_we_n_out <= 1'b1;
            ph_q           <= 4'd0;
            st_q           <= S_WHIGH;
          end
        end
        S_WHIGH: begin
          ph_q <= ph_q + 4'd1;
          if (ph_q == PH) begin
            ph_q <= 4'd0;
            if (idx_q == n_writes(op_q) - 3'd1) begin
              // Flash verifies internally; only status polling follows
              flash_dq_oe_out <= 1'b0; // R1 R3 R6
              first_q         <= 1'b1;
              st_q            <= S_POLL;
            end else begin
              idx_q <= idx_q + 3'd1;
              st_q  <= S_CMD;
            end
          end
        end
        S_POLL: begin
          flash_ce_n_out <= 1'b0;
          flash_oe_n_out <= 1'b0; // R16
          ph_q           <= ph_q + 4'd1;
          // Pins pass two sync stages, so sample late in the read
          if (ph_q == PH + 4'd2) begin
            ph_q <= 4'd0;
            st_q <= S_PSAMP;
          end
        end
        S_PSAMP: begin
          flash_oe_n_out <= 1'b1;
          tog_q          <= dq_s2_q[`FAPEC_TOGGLE_BIT];
          first_q        <= 1'b0;
          // Done when poll bit matches, or bit six stopped toggling
          if (poll_ok || (!first_q && tog_q == dq_s2_q[`FAPEC_TOGGLE_BIT])) begin // R5
            st_q <= S_DONE;
          end else if (tmr_done) begin
            timeout_out <= 1'b1; // R8 R9 R10
            st_q        <= S_DONE;
          end else begin
            st_q <= S_POLL;
          end
        end
        S_OESET: begin
          if (tmr_done) begin
            flash_we_n_out <= 1'b0; // R13
            st_q           <= S_PPULSE;
          end
        end
        S_PPULSE: begin
          if (tmr_done) begin
            flash_we_n_out <= 1'b1; // R11 R12
            st_q           <= S_DONE;
          end
        end
        S_DONE: begin
          flash_ce_n_out <= 1'b1;
          flash_oe_n_out <= 1'b1;
          done_out       <= 1'b1;
          st_q           <= S_IDLE;
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end
endmodule // fapec_host
`default_nettype wire

// File: verification/fapec_host_checker.sv
// Assertion checker bound to the flash program/erase host controller
`timescale 1ns/1ps
`default_nettype none
module fapec_host_checker #(
  parameter UNPROT_PULSE = 480000
) (
  input wire logic       sys_clk_in,
  input wire logic       reset_n_in,
  input wire logic       start_in,
  input wire logic [2:0] op_sel_in,
  input wire logic       ready_out,
  input wire logic       done_out,
  input wire logic       timeout_out,
  input wire logic [7:0] flash_dq_out,
  input wire logic       flash_dq_oe_out,
  input wire logic       flash_ce_n_out,
  input wire logic       flash_oe_n_out,
  input wire logic       flash_we_n_out
);
  logic [31:0] low_q;
  logic [2:0]  op_q;
  logic [31:0] oe_hi_q;
  // Width of the write pulse now ending, judged at its rising edge
  always @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      low_q   <= 32'h0000_0000;
      op_q    <= 3'h0;
      oe_hi_q <= 32'h0000_0000;
    end else begin
      low_q <= flash_we_n_out ? 32'h0000_0000 : low_q + 32'h0000_0001;
      // Selected, output enable high and no write yet: the set-up before a pulse
      oe_hi_q <= (flash_oe_n_out && !flash_ce_n_out && flash_we_n_out) ?
                 oe_hi_q + 32'h0000_0001 : 32'h0000_0000;
      if (start_in && ready_out) op_q <= op_sel_in;
    end
  end
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);
  write_gate_a: assert property (!flash_we_n_out |-> !flash_ce_n_out && flash_oe_n_out)
    else $error("write strobe outside a select");
  bus_clash_a: assert property (!flash_oe_n_out |-> !flash_dq_oe_out)
    else $error("data driven during a read");
  we_pulse_a: assert property ($fell(flash_we_n_out) |-> !flash_we_n_out [*3])
    else $error("write pulse too short");
  write_data_a: assert property (!flash_we_n_out && $past(!flash_we_n_out) |-> $stable(flash_dq_out))
    else $error("data moved during write pulse");
  done_pulse_a: assert property (done_out |-> ready_out ##1 !done_out)
    else $error("done not a single pulse");
  start_busy_a: assert property (start_in && ready_out && op_sel_in <= 3'h4 |=> !ready_out)
    else $error("valid start not taken");
  bad_op_a: assert property (start_in && ready_out && op_sel_in > 3'h4 |=> ready_out)
    else $error("unknown op taken");
  timeout_clear_a: assert property (start_in && ready_out && op_sel_in <= 3'h4 |=> !timeout_out)
    else $error("timeout kept over a start");
  protect_width_a: assert property ($rose(flash_we_n_out) && op_q == 3'h3 |-> low_q >= 400)
    else $error("protect pulse too short");
  unprot_width_a: assert property ($rose(flash_we_n_out) && op_q == 3'h4 |-> low_q >= UNPROT_PULSE)
    else $error("unprotect pulse too short");
  oe_setup_a: assert property ($fell(flash_we_n_out) && (op_q == 3'h3 || op_q == 3'h4)
    |-> oe_hi_q >= 160)
    else $error("output enable set-up too short");
  cover property (done_out && timeout_out);
  cover property (done_out && !timeout_out && op_q == 3'h2);
  cover property ($rose(flash_we_n_out) && op_q == 3'h4);
endmodule // fapec_host_checker
bind fapec_host fapec_host_checker #(.UNPROT_PULSE(UNPROT_PULSE)) i_fapec_host_checker (
  .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .start_in(start_in),
  .op_sel_in(op_sel_in), .ready_out(ready_out), .done_out(done_out),
  .timeout_out(timeout_out), .flash_dq_out(flash_dq_out), .flash_dq_oe_out(flash_dq_oe_out),
  .flash_ce_n_out(flash_ce_n_out), .flash_oe_n_out(flash_oe_n_out),
  .flash_we_n_out(flash_we_n_out));
`default_nettype wire

// File: verification/fapec_flash_model.sv
// Behavioural byte-wide flash that answers the host's strobes with status polling
`timescale 1ns/1ps
`default_nettype none
module fapec_flash_model (
  input  wire logic        ce_n_in,
  input  wire logic        oe_n_in,
  input  wire logic        we_n_in,
  input  wire logic [18:0] addr_in,
  input  wire logic [7:0]  dq_in,
  input  wire logic [7:0]  busy_reads_in,
  output var  logic [7:0]  dq_out
);
  logic [18:0] wa [0:7];
  logic [7:0]  wd [0:7];
  logic [7:0]  pd = 8'h00;
  logic [7:0]  rd = 8'h00;
  int          n = 0;
  int          busy = 0;
  bit          erase = 0;
  bit          tog = 0;
  realtime     fall_t = 0;
  realtime     we_low_t = 0;
  always @(negedge we_n_in) fall_t = $realtime;
  always @(posedge we_n_in) we_low_t = $realtime - fall_t;
  always @(posedge we_n_in) begin
    if (!ce_n_in && oe_n_in && n < 8) begin
      wa[n] = addr_in;
      wd[n] = dq_in;
      n = n + 1;
      if (n == 4 && wd[2] == 8'hA0) begin
        erase = 0;
        pd = dq_in;
        busy = busy_reads_in;
      end
      if (n == 6) begin
        erase = 1;
        busy = busy_reads_in;
      end
    end
  end
  always @(negedge oe_n_in) begin
    if (!ce_n_in && busy > 0) begin
      rd = {erase ? 1'b0 : ~pd[7], tog, 6'h00};
      tog = ~tog;
      busy = busy - 1;
    end else if (!ce_n_in) begin
      rd = erase ? 8'hFF : pd;
    end
  end
  // Released bus shows the inverse so a late sample cannot pass by chance
  assign dq_out = (!ce_n_in && !oe_n_in) ? rd : ~rd;
endmodule // fapec_flash_model
`default_nettype wire

// File: verification/fapec_host_test.sv
// Self-checking testbench for the flash program/erase host controller
`timescale 1ns/1ps
`default_nettype none
`include "fapec_defs.vh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin errors++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end
module fapec_host_test;
  logic        sys_clk = 0;
  logic        reset_n = 0;
  logic        start = 0;
  logic [2:0]  op_sel = 3'h0;
  logic [18:0] addr = 19'h0_0000;
  logic [7:0]  data = 8'h00;
  logic [7:0]  busy_reads = 8'h00;
  logic        ready, done, timeout, dq_oe, ce_n, oe_n, we_n;
  logic [18:0] f_addr;
  logic [7:0]  dq_o, dq_i;
  int          errors = 0;
  int          check_count = 0;
  always #12.5 sys_clk = ~sys_clk;
  fapec_host #(.PROG_MAX(200), .CHIP_MAX(200), .SECT_MAX(200), .UNPROT_PULSE(200),
    .LOAD_WINDOW(100)) i_fapec_host (.sys_clk_in(sys_clk), .reset_n_in(reset_n),
    .start_in(start), .op_sel_in(op_sel), .addr_in(addr), .data_in(data), .ready_out(ready),
    .done_out(done), .timeout_out(timeout), .flash_addr_out(f_addr), .flash_dq_out(dq_o),
    .flash_dq_oe_out(dq_oe), .flash_dq_in(dq_i), .flash_ce_n_out(ce_n),
    .flash_oe_n_out(oe_n), .flash_we_n_out(we_n));
  fapec_flash_model i_fapec_flash_model (.ce_n_in(ce_n), .oe_n_in(oe_n), .we_n_in(we_n),
    .addr_in(f_addr), .dq_in(dq_o), .busy_reads_in(busy_reads), .dq_out(dq_i));
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic run_op(input logic [2:0] op, input logic [18:0] a, input logic [7:0] d,
                        input logic [7:0] b);
    int k;
    i_fapec_flash_model.n = 0;
    busy_reads = b;
    @(negedge sys_clk);
    start = 1'b1;
    op_sel = op;
    addr = a;
    data = d;
    @(negedge sys_clk);
    start = 1'b0;
    for (k = 0; k < 20000 && done !== 1'b1; k++) @(negedge sys_clk);
    `CHK(done, 1'b1)
  endtask
  task automatic t_program(input logic [18:0] a, input logic [7:0] d);
    run_op(`FAPEC_OP_PROGRAM, a, d, 8'h03);
    `CHK(timeout, 1'b0)
    `CHK(i_fapec_flash_model.wd[3], d)
    `CHK(i_fapec_flash_model.wa[3], a)
    `CHK(i_fapec_flash_model.busy, 0)
    $display("test program %h done", d);
  endtask
  task automatic t_erase(input logic [2:0] op, input logic [7:0] code);
    run_op(op, 19'h5_A000, 8'h00, 8'h04);
    `CHK(timeout, 1'b0)
    `CHK(i_fapec_flash_model.wd[2], 8'h80)
    `CHK(i_fapec_flash_model.wd[5], code)
    if (op == `FAPEC_OP_SECTOR_ERASE)
      `CHK(i_fapec_flash_model.wa[5][18:13], 6'h2D)
    $display("test erase %h done", code);
  endtask
  task automatic t_pulse(input logic [2:0] op, input real min_ns);
    run_op(op, 19'h0_0000, 8'h00, 8'h00);
    `CHK(i_fapec_flash_model.we_low_t >= min_ns, 1'b1)
    $display("test pulse %h done", op);
  endtask
  task automatic t_timeout();
    run_op(`FAPEC_OP_PROGRAM, 19'h0_0010, 8'h3C, 8'hFF);
    `CHK(timeout, 1'b1)
    @(negedge sys_clk);
    start = 1'b1;
    op_sel = 3'h5;
    @(negedge sys_clk);
    start = 1'b0;
    `CHK(ready, 1'b1)
    `CHK(timeout, 1'b0)
    t_program(19'h0_0011, 8'h0F);
    $display("test timeout done");
  endtask
  task automatic t_reset();
    i_fapec_flash_model.n = 0;
    busy_reads = 8'hFF;
    @(negedge sys_clk);
    start = 1'b1;
    op_sel = `FAPEC_OP_CHIP_ERASE;
    @(negedge sys_clk);
    start = 1'b0;
    // Lands inside the second command write, with the strobe low
    repeat (12) @(negedge sys_clk);
    reset_n = 1'b0;
    @(negedge sys_clk);
    `CHK(we_n, 1'b1)
    `CHK(ce_n, 1'b1)
    `CHK(dq_oe, 1'b0)
    `CHK(ready, 1'b1)
    @(negedge sys_clk);
    reset_n = 1'b1;
    t_program(19'h0_0022, 8'hC3);
    $display("test reset done");
  endtask
  initial begin
    #500000;
    errors++;
    conclude();
  end
  initial begin
    repeat (2) @(negedge sys_clk);
    reset_n = 1'b1;
    `CHK(ready, 1'b1)
    t_program(19'h7_FFFF, 8'h5A);
    t_program(19'h0_0001, 8'hA5);
    t_erase(`FAPEC_OP_CHIP_ERASE, 8'h10);
    t_erase(`FAPEC_OP_SECTOR_ERASE, 8'h30);
    t_pulse(`FAPEC_OP_PROTECT, 10000.0);
    t_pulse(`FAPEC_OP_UNPROTECT, 5000.0);
    t_timeout();
    t_reset();
    conclude();
  end
endmodule // fapec_host_test
`default_nettype wire
